// file: bench/dioci_plc.sv
// Far-side sequencing controller model giving clean strobe pulses
`timescale 1ns/1ps
`default_nettype none
module dioci_plc #(
   parameter int W = 8
) (
   input wire logic pclk,
   input wire logic [W-1:0] trig,
   output logic [W-1:0] pulse
);
   logic [W-1:0] d1_reg = '0;
   logic [W-1:0] d2_reg = '0;
   // Two high cycles, then low before any new rise
   always @(posedge pclk) begin
      d1_reg <= trig;
      d2_reg <= d1_reg;
   end
   assign pulse = d1_reg | d2_reg;
endmodule : dioci_plc
`default_nettype wire

// file: bench/dioci_top_assertions.sv
// Pin-level checks for the dedicated I/O command decoder
`timescale 1ns/1ps
`default_nettype none
module dioci_top_assertions #(
   parameter int NSLOT = 32,
   parameter int NMECH = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic servo_disable_in,
   input wire logic operation_rights,
   input wire logic machine_lock,
   input wire logic emergency_stop_in,
   input wire logic [NSLOT-1:0] slot_start,
   input wire logic [NSLOT-1:0] slot_stop,
   input wire logic program_number_request,
   input wire logic servo_disabled_out,
   input wire logic servo_on_out,
   input wire logic [NMECH-1:0] mech_servo_on,
   input wire logic operation_rights_out,
   input wire logic machine_lock_out,
   input wire logic emergency_stop_flag,
   input wire logic [NSLOT-1:0] slot_running,
   input wire logic [NSLOT-1:0] slot_waiting,
   input wire logic program_number_flag,
   input wire logic line_number_flag
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence lock_rise;
      $rose(machine_lock);
   endsequence
   sequence prg_rise;
      $rose(program_number_request);
   endsequence
   sequence stop_hit;
      slot_stop[0] && slot_running[0];
   endsequence
   servo_echo_a: assert property (
      $past(presetn) |-> servo_disabled_out == $past(servo_disable_in)) else $error("echo wrong");
   servo_off_a: assert property (
      servo_disable_in |=> mech_servo_on == '0) else $error("servo not held off");
   servo_or_a: assert property (
      servo_on_out == |mech_servo_on) else $error("servo status not OR");
   rights_drop_a: assert property (
      !operation_rights |=> !operation_rights_out) else $error("rights without request");
   lock_toggle_a: assert property (
      lock_rise |=> machine_lock_out != $past(machine_lock_out)) else $error("lock not toggled");
   lock_steady_a: assert property (
      $past(presetn) && machine_lock && $past(machine_lock) |=> $stable(machine_lock_out))
      else $error("lock moved on level");
   estop_flag_a: assert property (
      emergency_stop_in |=> emergency_stop_flag && mech_servo_on == '0) else $error("estop flag");
   start_run_a: assert property (
      $rose(slot_start[0]) && !slot_stop[0] |=> slot_running[0]) else $error("slot not run");
   stop_wait_a: assert property (
      stop_hit |=> slot_waiting[0] && !slot_running[0]) else $error("slot not waiting");
   prg_flag_a: assert property (
      prg_rise |=> program_number_flag && !line_number_flag) else $error("program flag");
endmodule : dioci_top_assertions
bind dioci_top dioci_top_assertions #(.NSLOT(NSLOT), .NMECH(NMECH)) u_chk (
   .pclk(pclk), .presetn(presetn), .servo_disable_in(servo_disable_in),
   .operation_rights(operation_rights), .machine_lock(machine_lock),
   .emergency_stop_in(emergency_stop_in), .slot_start(slot_start), .slot_stop(slot_stop),
   .program_number_request(program_number_request), .servo_disabled_out(servo_disabled_out),
   .servo_on_out(servo_on_out), .mech_servo_on(mech_servo_on),
   .operation_rights_out(operation_rights_out), .machine_lock_out(machine_lock_out),
   .emergency_stop_flag(emergency_stop_flag), .slot_running(slot_running),
   .slot_waiting(slot_waiting), .program_number_flag(program_number_flag),
   .line_number_flag(line_number_flag));
`default_nettype wire

// file: bench/dioci_top_bench.sv
// Self-checking bench for the dedicated I/O command decoder
`timescale 1ns/1ps
`default_nettype none
module dioci_top_bench;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00, trig = 8'h00, pl;
   logic [31:0] pwdata = 32'h0, prdata, gp_out, rdv, v, sst = 32'h0, ssp = 32'h0, srun, swait;
   logic pready, pslverr, er, sdo, son, ro, mlo, evo, esf, pnf, lnf, irq;
   logic sdi = 0, rights = 0, esi = 0;
   logic [15:0] nf = 16'h0, nout, ln;
   logic [2:0] mso;
   int bad_count = 0, checks = 0, seed = 95, i;
   int slots[3];
   int m_int = 0, m_mask = 0;
   int ev_of[8] = '{dioci_pkg::EV_SERVO_ON, -1, dioci_pkg::EV_EVADE_REQ, dioci_pkg::EV_GP_CLEAR,
      dioci_pkg::EV_PRG_SEL, dioci_pkg::EV_OVRD_SEL, -1, -1};
   logic [15:0] nq[$];
   always #5 pclk = ~pclk;
   dioci_plc #(.W(8)) u_plc (.pclk(pclk), .trig(trig), .pulse(pl));
   dioci_top dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .servo_disable_in(sdi), .servo_power_on(pl[0]), .operation_rights(rights),
      .machine_lock(pl[1]), .evasion_return(pl[2]), .gp_output_clear(pl[3]),
      .emergency_stop_in(esi), .slot_start(sst), .slot_stop(ssp),
      .program_select_strobe(pl[4]), .override_select_strobe(pl[5]),
      .numeric_value_field(nf), .program_number_request(pl[6]), .line_number_request(pl[7]),
      .servo_disabled_out(sdo), .servo_on_out(son), .mech_servo_on(mso),
      .operation_rights_out(ro), .machine_lock_out(mlo), .evasion_return_out(evo),
      .emergency_stop_flag(esf), .slot_running(srun), .slot_waiting(swait),
      .numeric_value_out(nout), .program_number_flag(pnf), .line_number_flag(lnf),
      .gp_out(gp_out), .irq(irq));
   task automatic test_done();
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask : wt
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready === 1'b1) begin
         rdv = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end else begin
         bad_count++;
         test_done();
      end
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdv, e);
   endtask : rd
   task automatic pulse(input int b);
      trig <= 8'h01 << b;
      @(posedge pclk);
      trig <= 8'h00;
      if (ev_of[b] >= 0 && !(b == 0 && (sdi || esi))) m_int = m_int | (1 << ev_of[b]);
      wt(4);
   endtask : pulse
   task automatic spulse(input int b);
      sst <= 32'h1 << b;
      @(posedge pclk);
      sst <= 32'h0;
      wt(3);
   endtask : spulse
   initial begin
      wt(20000);
      bad_count++;
      test_done();
   end
   initial begin
      wt(4);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(dioci_pkg::ADDR_CTRL, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk(er, 1'b1);
      wr(dioci_pkg::ADDR_INT_MASK, 32'h3F);
      m_mask = 'h3F;
      pulse(0);
      chk(mso, 3'h7);
      chk(irq, (m_int & m_mask) != 0);
      rd(dioci_pkg::ADDR_INT_STATUS, m_int);
      m_int = 0;
      rd(dioci_pkg::ADDR_INT_STATUS, m_int);
      chk(irq, (m_int & m_mask) != 0);
      wr(dioci_pkg::ADDR_SERVO, 32'h1);
      wt(2);
      chk({mso, son}, 4'hD);
      sdi <= 1'b1;
      pulse(0);
      chk({mso, sdo}, 4'h1);
      sdi <= 1'b0;
      wt(2);
      chk(sdo, 1'b0);
      rd(dioci_pkg::ADDR_INT_STATUS, 32'h0);
      rights <= 1'b1;
      wt(3);
      chk(ro, 1'b0);
      wr(dioci_pkg::ADDR_CTRL, 32'h1);
      wt(2);
      chk(ro, 1'b1);
      rights <= 1'b0;
      wt(3);
      chk(ro, 1'b0);
      pulse(1);
      chk(mlo, 1'b1);
      pulse(1);
      chk(mlo, 1'b0);
      pulse(2);
      wt(3);
      chk(evo, 1'b1);
      wr(dioci_pkg::ADDR_CTRL, 32'h3);
      wt(2);
      chk(evo, 1'b0);
      v = $random(seed);
      wr(dioci_pkg::ADDR_GP_OUT, v);
      wt(1);
      chk(gp_out, v);
      pulse(3);
      rd(dioci_pkg::ADDR_GP_OUT, 32'h0);
      esi <= 1'b1;
      wt(3);
      esi <= 1'b0;
      m_int = m_int | (1 << dioci_pkg::EV_ESTOP);
      wt(3);
      chk(esf, 1'b1);
      wr(dioci_pkg::ADDR_CTRL, 32'h5);
      wt(2);
      chk(esf, 1'b0);
      rd(dioci_pkg::ADDR_INT_STATUS, m_int);
      m_int = 0;
      slots = '{0, 31, $random(seed) & 31};
      foreach (slots[k]) begin
         i = slots[k];
         spulse(i);
         chk(srun[i], 1'b1);
         ssp[i] <= 1'b1;
         wt(3);
         chk({srun[i], swait[i]}, 2'b01);
         spulse(i);
         chk(srun[i], 1'b0);
         ssp[i] <= 1'b0;
         spulse(i);
         chk({srun[i], swait[i]}, 2'b10);
         wr(dioci_pkg::ADDR_SLOT_END, 32'h1 << i);
         wt(2);
         chk(srun, 32'h0);
      end
      v = $random(seed);
      ln = ~v[15:0];
      nf <= v[15:0];
      pulse(4);
      rd(dioci_pkg::ADDR_PROGRAM, {16'h0, v[15:0]});
      nf <= v[31:16];
      pulse(5);
      rd(dioci_pkg::ADDR_OVERRIDE, {16'h0, v[31:16]});
      wr(dioci_pkg::ADDR_LINE, {16'h0, ln});
      nq.push_back(ln);
      pulse(7);
      chk({lnf, pnf, nout}, {2'b10, nq.pop_front()});
      nq.push_back(v[15:0]);
      pulse(6);
      chk({lnf, pnf, nout}, {2'b01, nq.pop_front()});
      rd(dioci_pkg::ADDR_INT_STATUS, m_int);
      m_int = 0;
      wr(dioci_pkg::ADDR_INT_MASK, 32'h0);
      m_mask = 0;
      pulse(4);
      chk(irq, (m_int & m_mask) != 0);
      wr(dioci_pkg::ADDR_INT_MASK, 32'h4);
      m_mask = 'h4;
      wt(2);
      chk(irq, (m_int & m_mask) != 0);
      rd(dioci_pkg::ADDR_INT_STATUS, m_int);
      m_int = 0;
      wt(2);
      chk(irq, (m_int & m_mask) != 0);
      wr(dioci_pkg::ADDR_GP_OUT, v);
      presetn <= 1'b0;
      wt(2);
      chk(gp_out, 32'h0);
      chk({pnf, lnf, mlo}, 3'h0);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(dioci_pkg::ADDR_CTRL, 32'h0);
      test_done();
   end
endmodule : dioci_top_bench
`default_nettype wire

// file: verilog/dioci_pkg.sv
// Package of constants for the dedicated I/O command interface
package dioci_pkg;
   localparam int NUM_SLOTS = 32;
   localparam int NUM_MECH = 3;
   localparam int NUM_WIDTH = 16;
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_INT_STATUS = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_INT_MASK = 8'h0C;
   localparam logic [ADDR_W-1:0] ADDR_PROGRAM = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_OVERRIDE = 8'h14;
   localparam logic [ADDR_W-1:0] ADDR_LINE = 8'h18;
   localparam logic [ADDR_W-1:0] ADDR_GP_OUT = 8'h1C;
   localparam logic [ADDR_W-1:0] ADDR_SLOT_RUN = 8'h20;
   localparam logic [ADDR_W-1:0] ADDR_SLOT_WAIT = 8'h24;
   localparam logic [ADDR_W-1:0] ADDR_SLOT_END = 8'h28;
   localparam logic [ADDR_W-1:0] ADDR_SERVO = 8'h2C;
   // Control register fields
   localparam int CTRL_GRANT_BIT = 0;
   localparam int CTRL_EVADE_DONE_BIT = 1;
   localparam int CTRL_ESTOP_CLR_BIT = 2;
   localparam logic CTRL_GRANT_RST = 1'b0;
   // Status register fields
   localparam int ST_SERVO_DIS_BIT = 0;
   localparam int ST_SERVO_ON_BIT = 1;
   localparam int ST_RIGHTS_BIT = 2;
   localparam int ST_LOCK_BIT = 3;
   localparam int ST_EVADE_BIT = 4;
   localparam int ST_ESTOP_BIT = 5;
   localparam int ST_PRG_FLAG_BIT = 6;
   localparam int ST_LINE_FLAG_BIT = 7;
   // Interrupt event bits
   localparam int INT_W = 6;
   localparam int EV_ESTOP = 0;
   localparam int EV_SERVO_ON = 1;
   localparam int EV_PRG_SEL = 2;
   localparam int EV_OVRD_SEL = 3;
   localparam int EV_EVADE_REQ = 4;
   localparam int EV_GP_CLEAR = 5;
   localparam logic [INT_W-1:0] INT_MASK_RST = 6'h00;
   localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
endpackage : dioci_pkg

// file: verilog/dioci_top.sv
// Dedicated I/O command decoder with APB register access
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Servo disable level holds servos off, echoed
// - Servo-on edge powers all mechanisms' servos
// - Servo-on status is OR over mechanisms
// - Rights output while requested and granted
// - Machine-lock edge toggles lock, output shows it
// - Evasion edge starts return, busy until done
// - Output-clear edge resets general-purpose outputs
// - Emergency stop input sets flag output, servos off
// - Slot start edge runs slot, shows running
// - Slot stop level pauses slot, shows wait
// - Program-select edge loads program from field
// - Override-select edge loads override from field
// - Numeric field in, matching numeric field out
// - Program request presents program, flag raised
// - Line request presents line number, flag raised
// - Level inputs act only while held on, except the emergency stop and slot wait flags, which stay set until cleared
module dioci_top #(
   parameter int NSLOT = dioci_pkg::NUM_SLOTS,
   parameter int NMECH = dioci_pkg::NUM_MECH,
   parameter int NW = dioci_pkg::NUM_WIDTH
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [dioci_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic servo_disable_in,
   input wire logic servo_power_on,
   input wire logic operation_rights,
   input wire logic machine_lock,
   input wire logic evasion_return,
   input wire logic gp_output_clear,
   input wire logic emergency_stop_in,
   input wire logic [NSLOT-1:0] slot_start,
   input wire logic [NSLOT-1:0] slot_stop,
   input wire logic program_select_strobe,
   input wire logic override_select_strobe,
   input wire logic [NW-1:0] numeric_value_field,
   input wire logic program_number_request,
   input wire logic line_number_request,
   output logic servo_disabled_out,
   output logic servo_on_out,
   output logic [NMECH-1:0] mech_servo_on,
   output logic operation_rights_out,
   output logic machine_lock_out,
   output logic evasion_return_out,
   output logic emergency_stop_flag,
   output logic [NSLOT-1:0] slot_running,
   output logic [NSLOT-1:0] slot_waiting,
   output logic [NW-1:0] numeric_value_out,
   output logic program_number_flag,
   output logic line_number_flag,
   output logic [31:0] gp_out,
   output logic irq
);

   function automatic logic rise(input logic cur, input logic prev);
      return cur & ~prev;
   endfunction : rise

   // Previous samples of edge-type inputs
   logic srv_on_d, lock_d, evade_d, gpclr_d, program_select_strobe_d, ovrsel_d, prgreq_d, linereq_d;
   logic [NSLOT-1:0] start_d;

   logic ev_srv_on, ev_lock, ev_evade, ev_gpclr, ev_program_select_strobe, ev_ovrsel, ev_prgreq, ev_linereq;
   logic [NSLOT-1:0] ev_start;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         srv_on_d <= 1'b0;
         lock_d <= 1'b0;
         evade_d <= 1'b0;
         gpclr_d <= 1'b0;
         program_select_strobe_d <= 1'b0;
         ovrsel_d <= 1'b0;
         prgreq_d <= 1'b0;
         linereq_d <= 1'b0;
         start_d <= '0;
      end else begin
         srv_on_d <= servo_power_on;
         lock_d <= machine_lock;
         evade_d <= evasion_return;
         gpclr_d <= gp_output_clear;
         program_select_strobe_d <= program_select_strobe;
         ovrsel_d <= override_select_strobe;
         prgreq_d <= program_number_request;
         linereq_d <= line_number_request;
         start_d <= slot_start;
      end
   end

   always_comb begin
      ev_srv_on = rise(servo_power_on, srv_on_d);
      ev_lock = rise(machine_lock, lock_d);
      ev_evade = rise(evasion_return, evade_d);
      ev_gpclr = rise(gp_output_clear, gpclr_d);
      ev_program_select_strobe = rise(program_select_strobe, program_select_strobe_d);
      ev_ovrsel = rise(override_select_strobe, ovrsel_d);
      ev_prgreq = rise(program_number_request, prgreq_d);
      ev_linereq = rise(line_number_request, linereq_d);
   end

   // APB decode
   logic setup_ph, access_ph, wr_en;
   logic [31:0] rd_mux;
   logic addr_ok;
   assign setup_ph = psel & ~penable;
   assign access_ph = psel & penable & pready;
   assign wr_en = access_ph & pwrite & ~pslverr;

   // Software registers
   logic grant_reg;
   logic [dioci_pkg::INT_W-1:0] int_status_reg, int_mask_reg, int_clr_reg, events;
   logic [NW-1:0] program_reg, override_reg, line_reg;

   // Address match for one register
   function automatic logic hit(input logic [dioci_pkg::ADDR_W-1:0] a,
      input logic [dioci_pkg::ADDR_W-1:0] r);
      return a == r;
   endfunction : hit

   logic wr_ctrl, wr_slot_end, wr_servo, wr_mask, wr_line, wr_gp, rd_int;
   assign wr_ctrl = wr_en && hit(paddr, dioci_pkg::ADDR_CTRL);
   assign wr_slot_end = wr_en && hit(paddr, dioci_pkg::ADDR_SLOT_END);
   assign wr_servo = wr_en && hit(paddr, dioci_pkg::ADDR_SERVO);
   assign wr_mask = wr_en && hit(paddr, dioci_pkg::ADDR_INT_MASK);
   assign wr_line = wr_en && hit(paddr, dioci_pkg::ADDR_LINE);
   assign wr_gp = wr_en && hit(paddr, dioci_pkg::ADDR_GP_OUT);
   assign rd_int = access_ph && !pwrite && hit(paddr, dioci_pkg::ADDR_INT_STATUS);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         grant_reg <= dioci_pkg::CTRL_GRANT_RST;
         int_mask_reg <= dioci_pkg::INT_MASK_RST;
         line_reg <= '0;
         gp_out <= dioci_pkg::DATA_ZERO;
      end else begin
         if (wr_ctrl) begin
            grant_reg <= pwdata[dioci_pkg::CTRL_GRANT_BIT];
         end
         if (wr_mask) begin
            int_mask_reg <= pwdata[dioci_pkg::INT_W-1:0];
         end
         if (wr_line) begin
            line_reg <= pwdata[NW-1:0];
         end
         if (ev_gpclr) begin
            gp_out <= dioci_pkg::DATA_ZERO;
         end else if (wr_gp) begin
            gp_out <= pwdata;
         end
      end
   end

   // Servo power per mechanism
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mech_servo_on <= '0;
         servo_disabled_out <= 1'b0;
         servo_on_out <= 1'b0;
      end else begin
         servo_disabled_out <= servo_disable_in;
         if (servo_disable_in || emergency_stop_in) begin
            mech_servo_on <= '0;
         end else if (ev_srv_on) begin
            mech_servo_on <= '1;
         end else if (wr_servo) begin
            mech_servo_on <= mech_servo_on & ~pwdata[NMECH-1:0];
         end
         if (servo_disable_in || emergency_stop_in) begin
            servo_on_out <= 1'b0;
         end else if (ev_srv_on) begin
            servo_on_out <= 1'b1;
         end else if (wr_servo) begin
            servo_on_out <= |(mech_servo_on & ~pwdata[NMECH-1:0]);
         end
      end
   end

   // Rights, lock, evasion return, emergency flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         operation_rights_out <= 1'b0;
         machine_lock_out <= 1'b0;
         evasion_return_out <= 1'b0;
         emergency_stop_flag <= 1'b0;
      end else begin
         operation_rights_out <= operation_rights & grant_reg;
         if (ev_lock) begin
            machine_lock_out <= ~machine_lock_out;
         end
         if (ev_evade) begin
            evasion_return_out <= 1'b1;
         end else if (wr_ctrl && pwdata[dioci_pkg::CTRL_EVADE_DONE_BIT]) begin
            evasion_return_out <= 1'b0;
         end
         if (emergency_stop_in) begin
            emergency_stop_flag <= 1'b1;
         end else if (wr_ctrl && pwdata[dioci_pkg::CTRL_ESTOP_CLR_BIT]) begin
            emergency_stop_flag <= 1'b0;
         end
      end
   end

   // Per-slot run and wait state
   genvar gi;
   generate
      for (gi = 0; gi < NSLOT; gi++) begin : g_slot
         assign ev_start[gi] = rise(slot_start[gi], start_d[gi]);
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               slot_running[gi] <= 1'b0;
               slot_waiting[gi] <= 1'b0;
            end else if (slot_stop[gi]) begin
               if (slot_running[gi]) begin
                  slot_waiting[gi] <= 1'b1;
               end
               slot_running[gi] <= 1'b0;
            end else if (ev_start[gi]) begin
               slot_running[gi] <= 1'b1;
               slot_waiting[gi] <= 1'b0;
            end else if (wr_slot_end && pwdata[gi]) begin
               slot_running[gi] <= 1'b0;
               slot_waiting[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // Selections and numeric output field
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         program_reg <= '0;
         override_reg <= '0;
         numeric_value_out <= '0;
         program_number_flag <= 1'b0;
         line_number_flag <= 1'b0;
      end else begin
         if (ev_program_select_strobe) begin
            program_reg <= numeric_value_field;
         end
         if (ev_ovrsel) begin
            override_reg <= numeric_value_field;
         end
         if (ev_prgreq) begin
            numeric_value_out <= program_reg;
            program_number_flag <= 1'b1;
            line_number_flag <= 1'b0;
         end else if (ev_linereq) begin
            numeric_value_out <= line_reg;
            program_number_flag <= 1'b0;
            line_number_flag <= 1'b1;
         end
      end
   end

   // Interrupt status, cleared by reading it; set wins
   always_comb begin
      events = '0;
      events[dioci_pkg::EV_ESTOP] = emergency_stop_in & ~emergency_stop_flag;
      events[dioci_pkg::EV_SERVO_ON] = ev_srv_on & ~servo_disable_in;
      events[dioci_pkg::EV_PRG_SEL] = ev_program_select_strobe;
      events[dioci_pkg::EV_OVRD_SEL] = ev_ovrsel;
      events[dioci_pkg::EV_EVADE_REQ] = ev_evade;
      events[dioci_pkg::EV_GP_CLEAR] = ev_gpclr;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_status_reg <= '0;
         irq <= 1'b0;
      end else begin
         if (rd_int) begin
            int_status_reg <= (int_status_reg & ~int_clr_reg) | events;
         end else begin
            int_status_reg <= int_status_reg | events;
         end
         irq <= |(int_status_reg & int_mask_reg);
      end
   end

   // Read mux
   always_comb begin
      rd_mux = dioci_pkg::DATA_ZERO;
      addr_ok = 1'b1;
      case (paddr)
         dioci_pkg::ADDR_CTRL: rd_mux[dioci_pkg::CTRL_GRANT_BIT] = grant_reg;
         dioci_pkg::ADDR_STATUS: begin
            rd_mux[dioci_pkg::ST_SERVO_DIS_BIT] = servo_disabled_out;
            rd_mux[dioci_pkg::ST_SERVO_ON_BIT] = servo_on_out;
            rd_mux[dioci_pkg::ST_RIGHTS_BIT] = operation_rights_out;
            rd_mux[dioci_pkg::ST_LOCK_BIT] = machine_lock_out;
            rd_mux[dioci_pkg::ST_EVADE_BIT] = evasion_return_out;
            rd_mux[dioci_pkg::ST_ESTOP_BIT] = emergency_stop_flag;
            rd_mux[dioci_pkg::ST_PRG_FLAG_BIT] = program_number_flag;
            rd_mux[dioci_pkg::ST_LINE_FLAG_BIT] = line_number_flag;
         end
         dioci_pkg::ADDR_INT_STATUS: rd_mux[dioci_pkg::INT_W-1:0] = int_status_reg;
         dioci_pkg::ADDR_INT_MASK: rd_mux[dioci_pkg::INT_W-1:0] = int_mask_reg;
         dioci_pkg::ADDR_PROGRAM: rd_mux[NW-1:0] = program_reg;
         dioci_pkg::ADDR_OVERRIDE: rd_mux[NW-1:0] = override_reg;
         dioci_pkg::ADDR_LINE: rd_mux[NW-1:0] = line_reg;
         dioci_pkg::ADDR_GP_OUT: rd_mux = gp_out;
         dioci_pkg::ADDR_SLOT_RUN: rd_mux[NSLOT-1:0] = slot_running;
         dioci_pkg::ADDR_SLOT_WAIT: rd_mux[NSLOT-1:0] = slot_waiting;
         dioci_pkg::ADDR_SLOT_END: rd_mux = dioci_pkg::DATA_ZERO;
         dioci_pkg::ADDR_SERVO: rd_mux[NMECH-1:0] = mech_servo_on;
         default: addr_ok = 1'b0;
      endcase
   end

   // APB answer: data captured in setup, ready in access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= dioci_pkg::DATA_ZERO;
         pready <= 1'b0;
         pslverr <= 1'b0;
         int_clr_reg <= '0;
      end else begin
         pready <= setup_ph;
         if (setup_ph) begin
            prdata <= pwrite ? dioci_pkg::DATA_ZERO : rd_mux;
            pslverr <= ~addr_ok;
            int_clr_reg <= int_status_reg;
         end else begin
            pslverr <= 1'b0;
         end
      end
   end

endmodule : dioci_top
`default_nettype wire
